/* File: rtl/epc_pkg.sv */
package epc_pkg;
  // register byte offsets inside the slave window
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MASK_UP = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_MASK_LO = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_SENSE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h14;
  // register width and reset value
  localparam int RW = 8;
  localparam logic [RW-1:0] REG_RST = 8'h00;
  // flag and enable bit positions, shared by flags, control and irq mask
  localparam int BIT_B = 7;
  localparam int BIT_A = 6;
  localparam int BIT_C = 5;
  localparam int BIT_PU = 4;
  localparam int BIT_PL = 3;
  localparam int NSRC = 5;
  localparam logic [RW-1:0] FLAG_BITS = 8'hf8;
  // sense control layout
  localparam int SNS_A_LO = 0;
  localparam int SNS_A_HI = 1;
  localparam int SNS_B_LO = 2;
  localparam int SNS_B_HI = 3;
  localparam int SNS_C_EDGE = 4;
  localparam logic [RW-1:0] SENSE_BITS = 8'h1f;
  // sampled pin vector layout
  localparam int NPIN = 19;
  localparam int PIN_A = 16;
  localparam int PIN_B = 17;
  localparam int PIN_C = 18;
  localparam int PC_UP_HI = 15;
  localparam int PC_UP_LO = 8;
  localparam int PC_LO_HI = 7;
  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [23:0] RDATA_PAD = 24'h000000;
  // bus front end states
  typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_RDWAIT} epc_bus_state_t;
endpackage : epc_pkg

/* File: rtl/epc_if.sv */
`timescale 1ns/10ps
`default_nettype none
// sampled pin levels and edges toward the flag logic
interface epc_pin_if import epc_pkg::*; ();
  logic [NPIN-1:0] level;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] fall;
  modport src(output level, output rise, output fall);
  modport dst(input level, input rise, input fall);
endinterface : epc_pin_if

// register access strobes from the bus front end
interface epc_reg_if import epc_pkg::*; ();
  logic wr;
  logic [ADDR_W-1:0] waddr;
  logic [RW-1:0] wdata;
  logic [ADDR_W-1:0] raddr;
  logic [RW-1:0] rdata;
  modport bus(output wr, output waddr, output wdata, output raddr, input rdata);
  modport regs(input wr, input waddr, input wdata, input raddr, output rdata);
endinterface : epc_reg_if
`default_nettype wire

/* File: rtl/epc_sense.sv */
`timescale 1ns/10ps
`default_nettype none
module epc_sense
  import epc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [epc_pkg::NPIN-1:0] pin_raw,
  input wire logic pin_c_buffer_off,
  epc_pin_if.src p
);
  import epc_pkg::*;
  logic [NPIN-1:0] s1_r; // first stage, read only by s2_r
  logic [NPIN-1:0] s2_r; // second stage
  logic [NPIN-1:0] prev_r; // last gated level for edge detect
  logic [NPIN-1:0] gated; // level after input buffer gating
  logic [NPIN-1:0] buf_mask; // clears pin c while its buffer is off

  //////////////////////////////////////////////////////////////////////
  // a disabled buffer reads as low, which can look like a falling edge
  assign buf_mask = {pin_c_buffer_off, {(NPIN-1){1'b0}}};
  assign gated = s2_r & ~buf_mask;
  assign p.level = gated;
  assign p.rise = gated & ~prev_r;
  assign p.fall = ~gated & prev_r;

  //////////////////////////////////////////////////////////////////////
  // two stage synchroniser plus history stage
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_r <= '0;
      s2_r <= '0;
      prev_r <= '0;
    end
    else
    begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      prev_r <= gated;
    end
  end
endmodule : epc_sense
`default_nettype wire

/* File: rtl/epc_bus.sv */
`timescale 1ns/10ps
`default_nettype none
module epc_bus
  import epc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output var logic hreadyout,
  output var logic hresp,
  output var logic [31:0] hrdata,
  epc_reg_if.bus r
);
  import epc_pkg::*;
  epc_bus_state_t state_r; // data phase kind
  logic [ADDR_W-1:0] addr_r; // captured address phase
  logic take; // valid word transfer in address phase

  //////////////////////////////////////////////////////////////////////
  // address phase qualification and register strobes
  assign take = hsel & hready & (htrans == HTRANS_NONSEQ) & (hsize == HSIZE_WORD);
  assign r.wr = (state_r == BUS_WRITE);
  assign r.waddr = addr_r;
  assign r.wdata = hwdata[RW-1:0];
  assign r.raddr = addr_r;

  //////////////////////////////////////////////////////////////////////
  // writes are zero wait, reads take one wait state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= BUS_IDLE;
      addr_r <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= '0;
    end
    else
    begin
      hresp <= 1'b0;
      case (state_r)
        BUS_RDWAIT:
        begin
          // registers already hold any preceding write
          hrdata <= {RDATA_PAD, r.rdata};
          hreadyout <= 1'b1;
          state_r <= BUS_IDLE;
        end
        default:
        begin
          if (take)
          begin
            addr_r <= haddr[ADDR_W-1:0];
            state_r <= hwrite ? BUS_WRITE : BUS_RDWAIT;
            hreadyout <= hwrite;
          end
          else
          begin
            state_r <= BUS_IDLE;
          end
        end
      endcase
    end
  end
endmodule : epc_bus
`default_nettype wire

/* File: rtl/epc_irq_flags.sv */
`timescale 1ns/10ps
`default_nettype none
module epc_irq_flags
  import epc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output var logic hreadyout,
  output var logic hresp,
  output var logic [31:0] hrdata,
  input wire logic ext_pin_a,
  input wire logic ext_pin_b,
  input wire logic ext_pin_c,
  input wire logic [7:0] change_inputs_upper,
  input wire logic [7:0] change_inputs_lower,
  input wire logic cpu_global_ie,
  input wire logic compat_mode,
  input wire logic pin_c_buffer_off,
  input wire logic [epc_pkg::NSRC-1:0] vec_ack,
  output var logic [epc_pkg::NSRC-1:0] vec_req,
  output var logic irq
);
  import epc_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // sense decode for pins a and b: any change, fall, rise, or level
  function automatic logic sense_hit(input logic hi, input logic lo,
                                     input logic rse, input logic fll);
    logic hit;
    hit = 1'b0;
    case ({hi, lo})
      2'b01: hit = rse | fll; // any logical change
      2'b10: hit = fll; // falling edge
      2'b11: hit = rse; // rising edge
      default: hit = 1'b0; // low level: no flag
    endcase
    return hit;
  endfunction : sense_hit

  //////////////////////////////////////////////////////////////////////
  // declarations
  epc_pin_if pins (); // synchronised levels and edges
  epc_reg_if regs (); // register strobes
  logic [RW-1:0] flags_r; // ext_irq_flags
  logic [RW-1:0] flags_nxt;
  logic [RW-1:0] mask_up_r; // pin_change_mask_upper
  logic [RW-1:0] mask_lo_r; // pin_change_mask_lower
  logic [RW-1:0] ctrl_r; // irq_control_register enables
  logic [RW-1:0] sense_r; // sense selects for pins a, b, c
  logic [RW-1:0] irq_mask_r; // gates flags onto irq
  logic wr_flags; // write strobes per register
  logic wr_mask_up;
  logic wr_mask_lo;
  logic wr_ctrl;
  logic wr_sense;
  logic wr_irq_mask;
  logic lvl_a; // pin a in low level mode
  logic lvl_b; // pin b in low level mode
  logic set_a;
  logic set_b;
  logic set_c;
  logic set_pu;
  logic set_pl;
  logic pc_ok; // pin change logic available
  logic [NSRC-1:0] set_vec; // set requests, flag order
  logic [NSRC-1:0] clr_vec; // clear requests, flag order
  logic [NSRC-1:0] hold_zero; // flags forced low
  logic [NSRC-1:0] src_pend; // pending sources
  logic [NSRC-1:0] src_en; // enabled sources
  logic [NSRC-1:0] w1c; // written ones to the flags

  //////////////////////////////////////////////////////////////////////
  // pin synchroniser and edge detector
  epc_sense u_sense (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_raw({ext_pin_c, ext_pin_b, ext_pin_a, change_inputs_upper, change_inputs_lower}),
    .pin_c_buffer_off(pin_c_buffer_off),
    .p(pins.src)
  );

  //////////////////////////////////////////////////////////////////////
  // bus front end
  // writes land with no wait, reads insert one wait state
  // hready comes back from outside, tied to hreadyout on a single slave bus
  epc_bus u_bus (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .r(regs.bus)
  );

  //////////////////////////////////////////////////////////////////////
  // write decode
  // only the data phase of a write raises these strobes
  assign wr_flags = regs.wr & (regs.waddr == OFF_FLAGS);
  assign wr_mask_up = regs.wr & (regs.waddr == OFF_MASK_UP);
  assign wr_mask_lo = regs.wr & (regs.waddr == OFF_MASK_LO);
  assign wr_ctrl = regs.wr & (regs.waddr == OFF_CTRL);
  assign wr_sense = regs.wr & (regs.waddr == OFF_SENSE);
  assign wr_irq_mask = regs.wr & (regs.waddr == OFF_IRQ_MASK);

  //////////////////////////////////////////////////////////////////////
  // read mux, unmapped offsets read zero
  // the bus captures this in the wait cycle after the address phase
  assign regs.rdata = (regs.raddr == OFF_FLAGS) ? flags_r :
                      (regs.raddr == OFF_MASK_UP) ? mask_up_r :
                      (regs.raddr == OFF_MASK_LO) ? mask_lo_r :
                      (regs.raddr == OFF_CTRL) ? ctrl_r :
                      (regs.raddr == OFF_SENSE) ? sense_r :
                      (regs.raddr == OFF_IRQ_MASK) ? irq_mask_r : REG_RST;

  //////////////////////////////////////////////////////////////////////
  // event detection
  // both sense bits zero means low level mode
  assign lvl_a = ~sense_r[SNS_A_HI] & ~sense_r[SNS_A_LO];
  assign lvl_b = ~sense_r[SNS_B_HI] & ~sense_r[SNS_B_LO];
  assign set_b = sense_hit(sense_r[SNS_B_HI], sense_r[SNS_B_LO],
                           pins.rise[PIN_B], pins.fall[PIN_B]);
  assign set_a = sense_hit(sense_r[SNS_A_HI], sense_r[SNS_A_LO],
                           pins.rise[PIN_A], pins.fall[PIN_A]);
  // an edge made by the buffer gating counts as a real one
  assign set_c = sense_r[SNS_C_EDGE] ? pins.rise[PIN_C] : pins.fall[PIN_C];
  // pin change detection is absent in compatibility mode
  assign pc_ok = ~compat_mode;
  // a change is either edge; the mask picks the pins that count
  assign set_pu = pc_ok & ctrl_r[BIT_PU] & (|((pins.rise[PC_UP_HI:PC_UP_LO]
                  | pins.fall[PC_UP_HI:PC_UP_LO]) & mask_up_r));
  assign set_pl = pc_ok & ctrl_r[BIT_PL] & (|((pins.rise[PC_LO_HI:0]
                  | pins.fall[PC_LO_HI:0]) & mask_lo_r));
  // gathered in flag order: b, a, c, upper, lower
  assign set_vec = {set_b, set_a, set_c, set_pu, set_pl};

  //////////////////////////////////////////////////////////////////////
  // flag update: set wins over clear, level mode forces zero
  // an event in the cycle of a clear must not be lost, so the set term
  // is or-ed in after the clear mask is applied
  assign w1c = wr_flags ? regs.wdata[BIT_B:BIT_PL] : '0;
  assign clr_vec = w1c | vec_ack;
  assign hold_zero = {lvl_b, lvl_a, 3'b000};
  assign flags_nxt = {(set_vec | (flags_r[BIT_B:BIT_PL] & ~clr_vec)) & ~hold_zero,
                      3'b000};

  //////////////////////////////////////////////////////////////////////
  // vector requests: flag or held low level, gated by enable and global bit
  // a level source requests while its pin stays low, with no flag behind it,
  // so the core sees it again after its handler if the pin is still low
  assign src_pend = flags_r[BIT_B:BIT_PL] | {lvl_b & ~pins.level[PIN_B],
                    lvl_a & ~pins.level[PIN_A], 3'b000};
  assign src_en = ctrl_r[BIT_B:BIT_PL] & {NSRC{cpu_global_ie}}
                  & {3'b111, pc_ok, pc_ok};

  //////////////////////////////////////////////////////////////////////
  // flag register
  // one register holds all five flags and the three zero bits
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flags_r <= REG_RST;
    end
    else
    begin
      flags_r <= flags_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // software control registers
  // reserved bits are dropped on write, so they read back zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mask_up_r <= REG_RST;
      mask_lo_r <= REG_RST;
      ctrl_r <= REG_RST;
      sense_r <= REG_RST;
      irq_mask_r <= REG_RST;
    end
    else
    begin
      if (wr_mask_up)
        mask_up_r <= regs.wdata;
      if (wr_mask_lo)
        mask_lo_r <= regs.wdata;
      if (wr_ctrl)
        ctrl_r <= regs.wdata & FLAG_BITS;
      if (wr_sense)
        sense_r <= regs.wdata & SENSE_BITS;
      if (wr_irq_mask)
        irq_mask_r <= regs.wdata & FLAG_BITS;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // registered outputs toward the core
  // both lag the flags by one cycle, which keeps the outputs glitch free
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      vec_req <= '0;
      irq <= 1'b0;
    end
    else
    begin
      vec_req <= src_pend & src_en;
      irq <= |(flags_r & irq_mask_r);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  // all checks run on the bus clock and stand down during reset
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_flag_b_set: assert property (set_b |=> flags_r[BIT_B])
    else $error("flag b not set after pin b event");
  a_flag_a_set: assert property (set_a |=> flags_r[BIT_A])
    else $error("flag a not set after pin a event");
  a_vec_follows: assert property (flags_r[BIT_C] && ctrl_r[BIT_C] && cpu_global_ie
    |=> vec_req[BIT_C-BIT_PL])
    else $error("vector c not requested");
  a_vec_needs_gie: assert property (!cpu_global_ie |=> vec_req == '0)
    else $error("vector request without global bit");
  a_ack_clears: assert property (vec_ack[BIT_PU-BIT_PL] && !set_pu
    |=> !flags_r[BIT_PU])
    else $error("upper flag survived acknowledge");
  a_w1c_clears: assert property (wr_flags && regs.wdata[BIT_C] && !set_c
    |=> !flags_r[BIT_C])
    else $error("flag c not cleared by one");
  a_w0_keeps: assert property (wr_flags && !regs.wdata[BIT_PL] && flags_r[BIT_PL]
    && !vec_ack[0] |=> flags_r[BIT_PL])
    else $error("flag lower lost on zero write");
  a_level_b_zero: assert property (lvl_b && $past(lvl_b) |-> !flags_r[BIT_B])
    else $error("flag b set in level mode");
  a_level_a_zero: assert property (lvl_a && $past(lvl_a) |-> !flags_r[BIT_A])
    else $error("flag a set in level mode");
  a_pin_c_edge: assert property ($rose(pins.level[PIN_C]) && sense_r[SNS_C_EDGE]
    |=> flags_r[BIT_C])
    else $error("rising pin c missed");
  a_upper_change: assert property (pc_ok && ctrl_r[BIT_PU] && mask_up_r[0]
    && pins.rise[PC_UP_LO] |=> flags_r[BIT_PU])
    else $error("upper change missed");
  a_lower_masked: assert property (mask_lo_r == '0 && !flags_r[BIT_PL] && !set_pl
    |=> !flags_r[BIT_PL])
    else $error("lower flag set with empty mask");
  a_compat_block: assert property (compat_mode |-> !set_pu && !set_pl)
    else $error("pin change seen in compatibility mode");
  a_low_bits_zero: assert property (flags_r[BIT_PL-1:0] == 3'b000)
    else $error("flag low bits not zero");

  //////////////////////////////////////////////////////////////////////
  // further checks on vectors, levels and the buffer gating

  // pin c falling edge while the select is zero
  a_pin_c_fall: assert property ($fell(pins.level[PIN_C])
    && !sense_r[SNS_C_EDGE] |=> flags_r[BIT_C])
    else $error("falling pin c missed");

  // buffer switched off over a high pin looks like a fall
  a_buf_edge: assert property ($rose(pin_c_buffer_off) && $past(pins.level[PIN_C])
    && !sense_r[SNS_C_EDGE] |=> flags_r[BIT_C])
    else $error("buffer off edge missed");

  // an empty upper mask keeps the upper flag clear
  a_upper_masked: assert property (mask_up_r == '0 && !flags_r[BIT_PU]
    |=> !flags_r[BIT_PU])
    else $error("upper flag set with empty mask");

  // low level on pin a requests with no flag behind it
  a_level_request: assert property (lvl_a && !pins.level[PIN_A]
    && ctrl_r[BIT_A] && cpu_global_ie |=> vec_req[BIT_A-BIT_PL])
    else $error("low level request missed");

  // high pin b in level mode requests nothing
  a_level_b_idle: assert property (lvl_b && $past(lvl_b) && pins.level[PIN_B]
    |=> !vec_req[BIT_B-BIT_PL])
    else $error("level request with pin b high");

  // compatibility mode drops both group vectors
  a_compat_novec: assert property (compat_mode
    |=> vec_req[BIT_PU-BIT_PL:0] == 2'b00)
    else $error("group vector in compatibility mode");

  // upper group vector needs its group enable
  a_upper_needs_en: assert property (!ctrl_r[BIT_PU] |=> !vec_req[BIT_PU-BIT_PL])
    else $error("upper vector without enable");

  // lower group vector needs its group enable
  a_lower_needs_en: assert property (!ctrl_r[BIT_PL] |=> !vec_req[0])
    else $error("lower vector without enable");

  // flag c drops after its handler is entered
  a_ack_flag_c: assert property (vec_ack[BIT_C-BIT_PL] && !set_c |=> !flags_r[BIT_C])
    else $error("flag c survived acknowledge");

  // writing one clears the upper flag too
  a_w1c_upper: assert property (wr_flags && regs.wdata[BIT_PU] && !set_pu
    |=> !flags_r[BIT_PU])
    else $error("upper flag not cleared by one");

  // main scenarios the bench should reach

  c_flag_b: cover property (set_b ##1 flags_r[BIT_B]);
  c_vec_upper: cover property (vec_req[BIT_PU-BIT_PL] ##1 vec_ack[BIT_PU-BIT_PL]);
  c_irq_rise: cover property ($rose(irq));
  c_set_and_clear: cover property (set_c && wr_flags && regs.wdata[BIT_C]);
  c_buf_fall: cover property ($rose(pin_c_buffer_off) ##1 flags_r[BIT_C]);
endmodule : epc_irq_flags
`default_nettype wire

/* File: dv/epc_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// cpu side: takes one vector at a time, lowest request bit first
module epc_cpu_model
  import epc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [epc_pkg::NSRC-1:0] vec_req,
  input wire logic take_en,
  input wire logic [3:0] ack_dly,
  output var logic [epc_pkg::NSRC-1:0] vec_ack
);
  import epc_pkg::*;
  logic [3:0] wait_r; // cycles spent before entering the handler
  logic [1:0] hold_r; // lets the request drop before the next pick
  // ack pulse of one cycle, promptly or after ack_dly cycles
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      vec_ack <= '0;
      wait_r <= 4'h0;
      hold_r <= 2'h0;
    end
    else
    begin
      vec_ack <= '0;
      if (hold_r != 2'h0)
        hold_r <= hold_r - 2'h1;
      else if (take_en && vec_req != '0)
      begin
        if (wait_r < ack_dly)
          wait_r <= wait_r + 4'h1;
        else
        begin
          vec_ack <= vec_req & (~vec_req + 5'h1);
          wait_r <= 4'h0;
          hold_r <= 2'h3;
        end
      end
    end
  end
endmodule : epc_cpu_model
`default_nettype wire

/* File: dv/tb_ext_pin_change_irq_flags.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_ext_pin_change_irq_flags;
  import epc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic pin_a, pin_b, pin_c, gie, compat, buf_off, take_en;
  logic [7:0] chg_up, chg_lo;
  logic [3:0] ack_dly;
  logic [NSRC-1:0] vack, vreq;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  int mflags = 0; // model of the flag register
  int mreg[6] = '{0, 0, 0, 0, 0, 0}; // model of the other registers
  logic [31:0] seed = 32'h2c40b705;
  //////////////////////////////////////////////////////////////////////////////
  epc_irq_flags dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_pin_a(pin_a),
    .ext_pin_b(pin_b), .ext_pin_c(pin_c), .change_inputs_upper(chg_up),
    .change_inputs_lower(chg_lo), .cpu_global_ie(gie), .compat_mode(compat),
    .pin_c_buffer_off(buf_off), .vec_ack(vack), .vec_req(vreq), .irq(irq));
  epc_cpu_model cpu_u (.hclk(hclk), .hresetn(hresetn), .vec_req(vreq), .take_en(take_en),
    .ack_dly(ack_dly), .vec_ack(vack));
  //////////////////////////////////////////////////////////////////////////////
  // free running clock
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // hang guard
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total = err_total + 1;
      final_report();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // writable bits of each register
  function automatic int keep(input logic [7:0] a);
    case (a)
      OFF_SENSE: return SENSE_BITS;
      OFF_CTRL, OFF_IRQ_MASK: return FLAG_BITS;
      default: return 8'hff;
    endcase
  endfunction : keep
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one single word transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic mwr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, {24'h0, d}, q);
    if (a == OFF_FLAGS)
      mflags = mflags & ~int'(d);
    else if (a <= OFF_IRQ_MASK)
      mreg[a[7:2]] = d & keep(a);
  endtask : mwr
  task automatic mrd(input logic [7:0] a);
    logic [31:0] q;
    int e;
    bus(1'b0, a, 32'h0, q);
    e = (a == OFF_FLAGS) ? mflags : (a <= OFF_IRQ_MASK) ? mreg[a[7:2]] : 0;
    chk("hrdata", e, q);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : mrd
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask : wt
  // vector requests and irq against the model
  task automatic outs();
    int v;
    v = gie ? ((mflags & mreg[3]) >> 3) : 0;
    chk("vec_req", v, {27'h0, vreq});
    chk("irq", ((mflags & mreg[5]) != 0), {31'h0, irq});
  endtask : outs
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {hsel, hwrite, gie, compat, buf_off, take_en} = 6'h0;
    {pin_a, pin_b, pin_c} = 3'h7;
    {haddr, hwdata, htrans, hsize, chg_up, chg_lo, ack_dly} = '0;
    hresetn = 1'b0;
    wt(16);
    hresetn <= 1'b1;
    wt(1);
    // reset values, unmapped place, read-only low flag bits
    for (int a = 0; a <= 24; a += 4)
      mrd(8'(a));
    mwr(OFF_FLAGS, 8'h07);
    mrd(OFF_FLAGS);
    mwr(OFF_MASK_UP, 8'(rnd()));
    mwr(OFF_MASK_LO, 8'(rnd()));
    mrd(OFF_MASK_UP);
    mrd(OFF_MASK_LO);
    // pin change groups under random enables, compat and toggles
    for (int i = 0; i < 10; i++)
    begin
      r = rnd();
      mwr(OFF_CTRL, {3'h0, r[4:3], 3'h0});
      mwr(OFF_FLAGS, 8'hf8);
      compat <= r[2];
      gie <= r[5];
      chg_up <= chg_up ^ r[31:24];
      chg_lo <= chg_lo ^ r[23:16];
      wt(6);
      if (!r[2] && r[4] && (r[31:24] & mreg[1]) != 0) mflags |= 'h10;
      if (!r[2] && r[3] && (r[23:16] & mreg[2]) != 0) mflags |= 'h08;
      mwr(OFF_FLAGS, 8'h00);
      mrd(OFF_FLAGS);
      outs();
    end
    compat <= 1'b0;
    // pin c: both edge selects, matching and opposite edges
    for (int i = 0; i < 4; i++)
    begin
      mwr(OFF_SENSE, 8'(i[1]) << 4);
      mwr(OFF_FLAGS, 8'hf8);
      pin_c <= ~pin_c;
      wt(6);
      if (pin_c == i[1]) mflags |= 'h20;
      mrd(OFF_FLAGS);
    end
    // pins a and b in change, fall and rise modes
    for (int i = 0; i < 6; i++)
    begin
      mwr(OFF_SENSE, 8'h10 | 8'((1 + i % 3) * 5));
      mwr(OFF_FLAGS, 8'hf8);
      pin_a <= ~pin_a;
      pin_b <= ~pin_b;
      wt(6);
      if (i % 3 == 0 || (i % 3 == 1 && !pin_a) || (i % 3 == 2 && pin_a)) mflags |= 'hc0;
      mrd(OFF_FLAGS);
    end
    // level mode clears set flags; a low pin requests with no flag
    mwr(OFF_SENSE, 8'h00);
    mflags &= ~'hc0;
    mrd(OFF_FLAGS);
    mwr(OFF_CTRL, 8'h40);
    gie <= 1'b1;
    pin_a <= 1'b0;
    wt(6);
    mrd(OFF_FLAGS);
    chk("vec_req", 32'h08, {27'h0, vreq});
    pin_a <= 1'b1;
    wt(6);
    // flag c with irq mask, write zero keeps, write one clears
    mwr(OFF_FLAGS, 8'hf8);
    mwr(OFF_IRQ_MASK, 8'h20);
    pin_c <= 1'b0;
    wt(6);
    mflags |= 'h20;
    outs();
    mwr(OFF_FLAGS, 8'h00);
    mrd(OFF_FLAGS);
    mwr(OFF_IRQ_MASK, 8'h00);
    wt(2);
    outs();
    mwr(OFF_FLAGS, 8'h20);
    wt(2);
    mrd(OFF_FLAGS);
    // vectoring: held off by the global bit, then acked by the cpu
    mwr(OFF_CTRL, 8'h30);
    mwr(OFF_MASK_UP, 8'h01);
    gie <= 1'b0;
    pin_c <= 1'b1;
    mwr(OFF_SENSE, 8'h00);
    pin_c <= 1'b0;
    chg_up <= chg_up ^ 8'h01;
    wt(6);
    mflags |= 'h30;
    outs();
    gie <= 1'b1;
    wt(3);
    outs();
    ack_dly <= 4'(rnd() % 8);
    take_en <= 1'b1;
    wt(40);
    mflags &= ~'h30;
    mrd(OFF_FLAGS);
    outs();
    take_en <= 1'b0;
    // buffer off turns a high pin c into a falling edge
    mwr(OFF_CTRL, 8'h00);
    pin_c <= 1'b1;
    wt(6);
    buf_off <= 1'b1;
    wt(6);
    mflags |= 'h20;
    mrd(OFF_FLAGS);
    buf_off <= 1'b0;
    final_report();
  end
endmodule : tb_ext_pin_change_irq_flags
`default_nettype wire
